// File: core/cecd_event_decoder.sv
`timescale 1ns/10ps
module cecd_event_decoder (
    input  wire logic                   mclk_i,
    input  wire logic                   sys_rst_i,
    input  wire cecd_pkg::cecd_core_ev_s core_ev_i,
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [11:0]            paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    output logic      [1:0]             count_pulse_o
);

    logic [15:0] sel_reg [2];
    logic [31:0] cnt_reg [2];
    logic        hit     [2];

    cecd_pkg::cecd_core_ev_s ev;
    logic        help_simd;
    logic        help_x87;
    logic        apb_acc;
    logic        apb_map;
    logic        apb_wr;

    // core strobes come from logic on this clock, used as is
    assign ev = core_ev_i;

    assign help_simd = ev.simd_fp_op &
                       ((ev.simd_denorm_in & ~ev.denormal_input_zeroing) |
                        (ev.simd_underflow & ~ev.underflow_flush_zero));

    assign help_x87 = ev.x87_op &
                      (ev.x87_nan_denorm_load | ev.x87_div_zero | ev.x87_underflow);

    // per-counter decode of selection into one condition
    for (genvar g = 0; g < 2; g++) begin : g_dec
        logic [7:0] evn;
        logic [7:0] um;
        assign evn = sel_reg[g][cecd_pkg::CECD_SEL_EV_LSB +: 8];
        assign um  = sel_reg[g][cecd_pkg::CECD_SEL_UM_LSB +: 8];

        always_comb begin
            hit[g] = 1'b0;
            case (evn)
                cecd_pkg::CECD_EV_DISAMB: begin
                    if (um == cecd_pkg::CECD_UM_01)
                        hit[g] = ev.order_flush;
                    else if (um == cecd_pkg::CECD_UM_02)
                        hit[g] = ev.load_disamb;
                end
                cecd_pkg::CECD_EV_WALK: begin
                    if (um == cecd_pkg::CECD_UM_01)
                        hit[g] = ev.dtlb_walk_start | ev.itlb_walk_start;
                    else if (um == cecd_pkg::CECD_UM_02)
                        hit[g] = ev.walk_busy;
                end
                cecd_pkg::CECD_EV_FPCOMP: begin
                    hit[g] = (g == 0) && (um == cecd_pkg::CECD_UM_00) && ev.fp_comp_uop;
                end
                cecd_pkg::CECD_EV_FPHELP: begin
                    hit[g] = (g == 1) && (help_simd | help_x87);
                end
                cecd_pkg::CECD_EV_PRODUCT: begin
                    hit[g] = (g == 1) && (ev.int_product | ev.fp_product);
                end
                cecd_pkg::CECD_EV_DIV: begin
                    hit[g] = (g == 1) && (ev.int_div | ev.fp_div | ev.fp_sqrt);
                end
                cecd_pkg::CECD_EV_DIVBUSY: begin
                    hit[g] = (g == 0) && (um == cecd_pkg::CECD_UM_00) && ev.div_busy;
                end
                default: hit[g] = 1'b0;
            endcase
        end
    end

    assign apb_acc = psel_i & penable_i;
    // writes land only on the completing edge, pready already high
    assign apb_wr  = apb_acc & pwrite_i & pready_o;
    assign apb_map = (paddr_i == cecd_pkg::CECD_SEL0_ADDR) |
                     (paddr_i == cecd_pkg::CECD_SEL1_ADDR) |
                     (paddr_i == cecd_pkg::CECD_CNT0_ADDR) |
                     (paddr_i == cecd_pkg::CECD_CNT1_ADDR);

    // selection registers
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sel_reg[0] <= cecd_pkg::CECD_SEL_RESET;
            sel_reg[1] <= cecd_pkg::CECD_SEL_RESET;
        end else if (apb_wr) begin
            if (paddr_i == cecd_pkg::CECD_SEL0_ADDR)
                sel_reg[0] <= pwdata_i[15:0];
            if (paddr_i == cecd_pkg::CECD_SEL1_ADDR)
                sel_reg[1] <= pwdata_i[15:0];
        end
    end

    // counters; a software write wins over a same-cycle count
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_reg[0] <= cecd_pkg::CECD_CNT_RESET;
            cnt_reg[1] <= cecd_pkg::CECD_CNT_RESET;
        end else begin
            if (apb_wr && paddr_i == cecd_pkg::CECD_CNT0_ADDR)
                cnt_reg[0] <= pwdata_i;
            else if (hit[0])
                cnt_reg[0] <= cnt_reg[0] + cecd_pkg::CECD_CNT_ONE;
            if (apb_wr && paddr_i == cecd_pkg::CECD_CNT1_ADDR)
                cnt_reg[1] <= pwdata_i;
            else if (hit[1])
                cnt_reg[1] <= cnt_reg[1] + cecd_pkg::CECD_CNT_ONE;
        end
    end

    // registered qualified event strobes
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i)
            count_pulse_o <= 2'b00;
        else
            count_pulse_o <= {hit[1], hit[0]};
    end

    // apb answer: one wait state, pready registered
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= cecd_pkg::CECD_CNT_RESET;
        end else begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~apb_map;
            prdata_o  <= 32'h0000_0000;
            if (psel_i && penable_i && !pready_o && !pwrite_i) begin
                case (paddr_i)
                    cecd_pkg::CECD_SEL0_ADDR: prdata_o <= {16'h0000, sel_reg[0]};
                    cecd_pkg::CECD_SEL1_ADDR: prdata_o <= {16'h0000, sel_reg[1]};
                    cecd_pkg::CECD_CNT0_ADDR: prdata_o <= cnt_reg[0];
                    cecd_pkg::CECD_CNT1_ADDR: prdata_o <= cnt_reg[1];
                    default:                  prdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // assertions
    // one-cycle conditions shared by the properties below
    sequence s_flush_sel0;
        sel_reg[0] == {cecd_pkg::CECD_UM_01, cecd_pkg::CECD_EV_DISAMB} && ev.order_flush;
    endsequence
    sequence s_disamb_sel1;
        sel_reg[1] == {cecd_pkg::CECD_UM_02, cecd_pkg::CECD_EV_DISAMB} && ev.load_disamb;
    endsequence
    sequence s_walk_start_sel0;
        sel_reg[0] == {cecd_pkg::CECD_UM_01, cecd_pkg::CECD_EV_WALK} &&
        (ev.dtlb_walk_start || ev.itlb_walk_start);
    endsequence
    sequence s_walk_busy_sel1;
        sel_reg[1] == {cecd_pkg::CECD_UM_02, cecd_pkg::CECD_EV_WALK} && ev.walk_busy;
    endsequence
    sequence s_fpcomp_sel0;
        sel_reg[0] == {cecd_pkg::CECD_UM_00, cecd_pkg::CECD_EV_FPCOMP} && ev.fp_comp_uop;
    endsequence
    sequence s_help_sel1;
        sel_reg[1][7:0] == cecd_pkg::CECD_EV_FPHELP;
    endsequence
    sequence s_simd_help_case;
        ev.simd_fp_op &&
        ((ev.simd_denorm_in && !ev.denormal_input_zeroing) ||
         (ev.simd_underflow && !ev.underflow_flush_zero));
    endsequence
    sequence s_x87_help_case;
        ev.x87_op && (ev.x87_nan_denorm_load || ev.x87_div_zero || ev.x87_underflow);
    endsequence
    sequence s_div_sel1;
        sel_reg[1][7:0] == cecd_pkg::CECD_EV_DIV &&
        (ev.int_div || ev.fp_div || ev.fp_sqrt);
    endsequence
    sequence s_divbusy_sel0;
        sel_reg[0] == {cecd_pkg::CECD_UM_00, cecd_pkg::CECD_EV_DIVBUSY} && ev.div_busy;
    endsequence
    // a software write to a counter overrides the count
    sequence s_no_write;
        !apb_wr;
    endsequence

    AST_FLUSH_COUNT: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_flush_sel0 |=> count_pulse_o[0])
        else $error("flush cycle missed");
    AST_FLUSH_ADD: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_flush_sel0 ##0 s_no_write |=> cnt_reg[0] == $past(cnt_reg[0]) + cecd_pkg::CECD_CNT_ONE)
        else $error("flush cycle not added");
    AST_DISAMB_COUNT: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_disamb_sel1 |=> count_pulse_o[1])
        else $error("disambiguated load missed");
    AST_WALK_START: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_walk_start_sel0 |=> count_pulse_o[0])
        else $error("page walk start missed");
    AST_WALK_BUSY: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_walk_busy_sel1 |=> count_pulse_o[1])
        else $error("page walk cycle missed");
    AST_WALK_CYCLES: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (sel_reg[1] == {cecd_pkg::CECD_UM_02, cecd_pkg::CECD_EV_WALK} && !ev.walk_busy)
        |=> !count_pulse_o[1]) else $error("walk cycle counted while idle");
    AST_FPCOMP_COUNT: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_fpcomp_sel0 |=> count_pulse_o[0])
        else $error("fp compute uop missed");
    AST_FPCOMP_ONLY_ZERO: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (sel_reg[1][7:0] == cecd_pkg::CECD_EV_FPCOMP) |=>
        ($stable(cnt_reg[1]) || $past(apb_wr && paddr_i == cecd_pkg::CECD_CNT1_ADDR)))
        else $error("fp compute counted in counter one");
    AST_SIMD_HELP: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_help_sel1 ##0 s_simd_help_case |=> count_pulse_o[1])
        else $error("simd help case missed");
    AST_X87_HELP: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_help_sel1 ##0 s_x87_help_case |=> count_pulse_o[1])
        else $error("x87 help case missed");
    AST_HELP_QUIET: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (sel_reg[1][7:0] == cecd_pkg::CECD_EV_FPHELP && !help_simd && !help_x87)
        |=> !count_pulse_o[1]) else $error("help counted without a help case");
    AST_HELP_ONE_ONLY: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (sel_reg[0][7:0] == cecd_pkg::CECD_EV_FPHELP) |=> !count_pulse_o[0])
        else $error("help counted in counter zero");
    AST_PRODUCT_COUNT: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (sel_reg[1] == {8'h00, cecd_pkg::CECD_EV_PRODUCT} && ev.int_product && !apb_acc)
        |=> cnt_reg[1] == $past(cnt_reg[1]) + cecd_pkg::CECD_CNT_ONE)
        else $error("multiply not counted");
    AST_PRODUCT_ONE_ONLY: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (sel_reg[0][7:0] == cecd_pkg::CECD_EV_PRODUCT) |=> !count_pulse_o[0])
        else $error("multiply counted in counter zero");
    AST_DIV_COUNT: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_div_sel1 |=> count_pulse_o[1])
        else $error("divide missed");
    AST_DIV_ONE_ONLY: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (sel_reg[0][7:0] == cecd_pkg::CECD_EV_DIV) |=> !count_pulse_o[0])
        else $error("divide counted in counter zero");
    AST_DIVBUSY_PULSE: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_divbusy_sel0 |=> count_pulse_o[0])
        else $error("divider busy cycle missed");
    AST_DIVBUSY_ONLY_ZERO: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (sel_reg[1][7:0] == cecd_pkg::CECD_EV_DIVBUSY) |=> !count_pulse_o[1])
        else $error("divider busy counted in counter one");
    AST_COUNT_HOLD: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        (!hit[0] && !(apb_wr && paddr_i == cecd_pkg::CECD_CNT0_ADDR)) |=> $stable(cnt_reg[0]))
        else $error("counter zero moved without a hit");

endmodule : cecd_event_decoder

// File: core/cecd_pkg.sv
package cecd_pkg;

    // event selection codes
    localparam logic [7:0] CECD_EV_DISAMB  = 8'h09;
    localparam logic [7:0] CECD_EV_WALK    = 8'h0c;
    localparam logic [7:0] CECD_EV_FPCOMP  = 8'h10;
    localparam logic [7:0] CECD_EV_FPHELP  = 8'h11;
    localparam logic [7:0] CECD_EV_PRODUCT = 8'h12;
    localparam logic [7:0] CECD_EV_DIV     = 8'h13;
    localparam logic [7:0] CECD_EV_DIVBUSY = 8'h14;

    // unit masks
    localparam logic [7:0] CECD_UM_00 = 8'h00;
    localparam logic [7:0] CECD_UM_01 = 8'h01;
    localparam logic [7:0] CECD_UM_02 = 8'h02;

    // register map, byte addresses
    localparam logic [11:0] CECD_SEL0_ADDR = 12'h000;
    localparam logic [11:0] CECD_SEL1_ADDR = 12'h004;
    localparam logic [11:0] CECD_CNT0_ADDR = 12'h008;
    localparam logic [11:0] CECD_CNT1_ADDR = 12'h00c;

    // selection register fields, reset values and the counter increment
    localparam int CECD_SEL_EV_LSB = 0;
    localparam int CECD_SEL_UM_LSB = 8;
    localparam logic [15:0] CECD_SEL_RESET = 16'h0000;
    localparam logic [31:0] CECD_CNT_RESET = 32'h0000_0000;
    localparam logic [31:0] CECD_CNT_ONE   = 32'h0000_0001;

    // raw event strobes from the core pipeline
    typedef struct packed {
        logic order_flush;
        logic load_disamb;
        logic dtlb_walk_start;
        logic itlb_walk_start;
        logic walk_busy;
        logic fp_comp_uop;
        logic simd_fp_op;
        logic simd_denorm_in;
        logic denormal_input_zeroing;
        logic simd_underflow;
        logic underflow_flush_zero;
        logic x87_op;
        logic x87_nan_denorm_load;
        logic x87_div_zero;
        logic x87_underflow;
        logic int_product;
        logic fp_product;
        logic int_div;
        logic fp_div;
        logic fp_sqrt;
        logic div_busy;
    } cecd_core_ev_s;

endpackage : cecd_pkg

// File: test/cecd_core_model.sv
`timescale 1ns/10ps
module cecd_core_model (
    input  wire logic               mclk_i,
    output cecd_pkg::cecd_core_ev_s core_ev_o
);
    // strobes sit low between bursts, as the pipeline drops them
    initial core_ev_o = '0;

    task automatic drive(input logic [20:0] ev, input int n);
        repeat (n) begin
            @(posedge mclk_i);
            core_ev_o <= cecd_pkg::cecd_core_ev_s'(ev);
        end
        @(posedge mclk_i);
        core_ev_o <= '0;
    endtask : drive
endmodule : cecd_core_model

// File: test/cecd_event_decoder_tb.sv
`timescale 1ns/10ps
module cecd_event_decoder_tb;
    logic                    mclk_i    = 1'b0;
    logic                    sys_rst_i = 1'b1;
    logic                    psel_i    = 1'b0;
    logic                    penable_i = 1'b0;
    logic                    pwrite_i  = 1'b0;
    logic [11:0]             paddr_i   = 12'h000;
    logic [31:0]             pwdata_i  = 32'h0000_0000;
    logic [31:0]             prdata_o;
    logic                    pready_o;
    logic                    pslverr_o;
    logic [1:0]              count_pulse_o;
    cecd_pkg::cecd_core_ev_s core_ev;
    int                      error_cnt = 0;
    int                      checked   = 0;

    always #12.5 mclk_i = ~mclk_i;

    cecd_core_model model_u (.mclk_i(mclk_i), .core_ev_o(core_ev));
    cecd_event_decoder dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .core_ev_i(core_ev),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .count_pulse_o(count_pulse_o));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge mclk_i);
        psel_i    <= 1'b1;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        // only the watchdog ends a wait that never completes
        do begin
            @(posedge mclk_i);
        end while (pready_o !== 1'b1);
        q = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, exp);
        check({31'h0, e}, {31'h0, exp_err});
    endtask : rd

    // preload both counters, burst the strobe, then read back
    task automatic hit(input logic [15:0] sel, input logic [20:0] ev, input int n,
                       input logic [1:0] exp);
        wr(cecd_pkg::CECD_SEL0_ADDR, {16'h0000, sel});
        wr(cecd_pkg::CECD_SEL1_ADDR, {16'h0000, sel});
        wr(cecd_pkg::CECD_CNT0_ADDR, 32'h0000_0010);
        wr(cecd_pkg::CECD_CNT1_ADDR, 32'h0000_0010);
        model_u.drive(ev, n);
        @(posedge mclk_i);
        check({30'h0, count_pulse_o}, {30'h0, exp});
        rd(cecd_pkg::CECD_CNT0_ADDR, 32'h0000_0010 + (exp[0] ? 32'(n) : 32'h0), 1'b0);
        rd(cecd_pkg::CECD_CNT1_ADDR, 32'h0000_0010 + (exp[1] ? 32'(n) : 32'h0), 1'b0);
    endtask : hit

    task automatic t_regs;
        for (int a = 0; a < 16; a += 4) begin
            rd(12'(a), 32'h0, 1'b0);
        end
        wr(cecd_pkg::CECD_SEL0_ADDR, 32'hffff_0209);
        rd(cecd_pkg::CECD_SEL0_ADDR, 32'h0000_0209, 1'b0);
        rd(12'h010, 32'h0, 1'b1);
        $display("test regs done");
    endtask : t_regs

    task automatic t_mem;
        hit(16'h0109, 21'h100000, 1, 2'b11);
        hit(16'h0209, 21'h080000, 3, 2'b11);
        hit(16'h0209, 21'h100000, 2, 2'b00);
        hit(16'h010c, 21'h040000, 1, 2'b11);
        hit(16'h010c, 21'h020000, 2, 2'b11);
        hit(16'h020c, 21'h010000, 5, 2'b11);
        $display("test mem done");
    endtask : t_mem

    // restricted events: only the permitted counter may move
    task automatic t_restrict;
        hit(16'h0010, 21'h008000, 2, 2'b01);
        hit(16'h0014, 21'h000001, 4, 2'b01);
        hit(16'h0110, 21'h008000, 1, 2'b00);
        hit(16'h0114, 21'h000001, 1, 2'b00);
        for (int k = 4; k < 6; k++) begin
            hit(16'h0012, 21'h1 << k, 1, 2'b10);
        end
        for (int k = 1; k < 4; k++) begin
            hit(16'h0013, 21'h1 << k, 2, 2'b10);
        end
        $display("test restrict done");
    endtask : t_restrict

    // simd cases with zeroing or flush on must not count
    task automatic t_help;
        logic [20:0] hv [7] = '{21'h6000, 21'h7000, 21'h4800, 21'h4c00, 21'h0300,
                                21'h0280, 21'h0240};
        logic [1:0]  hx [7] = '{2'b10, 2'b00, 2'b10, 2'b00, 2'b10, 2'b10, 2'b10};
        for (int k = 0; k < 7; k++) begin
            hit(16'h0511, hv[k], 1, hx[k]);
        end
        $display("test help done");
    endtask : t_help

    // a mid-run reset clears selections, counters and answers
    task automatic t_reset;
        wr(cecd_pkg::CECD_SEL1_ADDR, 32'h0000_0012);
        wr(cecd_pkg::CECD_CNT1_ADDR, 32'h0000_0033);
        @(posedge mclk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        check({30'h0, pready_o, pslverr_o}, 32'h0);
        check({30'h0, count_pulse_o}, 32'h0);
        rd(cecd_pkg::CECD_SEL1_ADDR, 32'h0, 1'b0);
        rd(cecd_pkg::CECD_CNT1_ADDR, 32'h0, 1'b0);
        hit(16'h0012, 21'h000020, 2, 2'b10);
        $display("test reset done");
    endtask : t_reset

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_regs;
        t_mem;
        t_restrict;
        t_help;
        t_reset;
        final_report;
    end

    initial begin
        repeat (5000) @(posedge mclk_i);
        error_cnt++;
        final_report;
    end
endmodule : cecd_event_decoder_tb
